// [shared/sps_pkg.sv]
package sps_pkg;

  // Setpoint word width
  localparam int SP_W = 16;
  // Interval time width (time base ticks)
  localparam int TM_W = 16;
  // Number of program outputs
  localparam int NOUT = 6;
  // Interval capacity of each program
  localparam int P1_IVL = 10;
  localparam int P2_IVL = 5;
  localparam int TOT_IVL = P1_IVL + P2_IVL;
  localparam int IX_W = 4;
  // Time base: one tick per second at 250 MHz
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 1000000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  // Static/dynamic start selector codes
  localparam logic [1:0] START_DYN = 2'h2;
  // Tracking selector code that disables tracking
  localparam logic [1:0] TRACK_OFF = 2'h1;
  // Reset values
  localparam logic [SP_W-1:0] SP_RST = 16'h0000;
  localparam logic [TM_W-1:0] TM_RST = 16'h0000;
  localparam logic [NOUT-1:0] OUT_RST = 6'h00;
  localparam logic [IX_W-1:0] IX_RST = 4'h0;

  // One interval of the program table
  typedef struct packed {
    logic [TM_W-1:0] dur;
    logic [SP_W-1:0] target;
    logic [NOUT-1:0] outs;
  } sps_ivl_s;

  // Configuration selectors
  typedef struct packed {
    logic [1:0] start_input_static_dynamic_select;
    logic [1:0] setpoint_tracking_select;
    logic       safety_tracking_select;
    logic       cascade_en;
    logic       program_config_menu;
  } sps_cfg_s;

  // Program sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP} sps_state_e;

endpackage : sps_pkg

// [core/sps_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; change taken when stages two and three agree
module sps_sync
  import sps_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);
  logic [2:0] sh_ff;   // Sync chain
  logic       q_ff;    // Accepted level
  logic [2:0] nxt_sh;
  logic       nxt_q;

  // Next values
  always_comb
  begin
    nxt_sh = {sh_ff[1:0], din};
    nxt_q  = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : q_ff;
  end

  // Registers
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sh_ff <= 3'h0;
      q_ff  <= 1'b0;
    end
    else
    begin
      sh_ff <= nxt_sh;
      q_ff  <= nxt_q;
    end
  end

  assign dout = q_ff;
endmodule : sps_sync
`default_nettype wire

// [core/sps_core.sv]
`timescale 1ns/1ps
`default_nettype none
module sps_core
  import sps_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  program_reset_input,     // Active-high reset request
  input  wire logic                  program_start_input,     // Start signal pin
  input  wire logic                  program_select_input,    // Program choice pin
  input  wire logic                  manual_mode,             // Manual, tracking or safety
  input  wire logic                  int_key_press,           // Front key toggle pulse
  input  wire sps_cfg_s              cfg,                     // Selectors
  input  wire sps_ivl_s              ivl_tab [TOT_IVL],       // Program table
  input  wire logic [SP_W-1:0]       safety_setpoint,         // Safety setpoint
  output logic [SP_W-1:0]            active_setpoint,         // Active setpoint
  output logic [SP_W-1:0]            internal_setpoint,       // Internal setpoint
  output logic [NOUT-1:0]            program_outputs,         // Interval outputs
  output logic                       clock_running,           // Program clock runs
  output logic                       internal_led,            // Internal indicator
  output logic                       internal_setpoint_ready_output,
  output logic                       no_program_operation_alarm,
  output logic [IX_W-1:0]            interval_index,          // Current interval
  output logic [TM_W-1:0]            remaining_time,          // Remaining in interval
  output logic                       program_two_active       // Program two selected
);

  // Synchronised pin levels
  logic rst_s, start_s, psel_s;
  sps_sync u_rst (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(program_reset_input), .dout(rst_s));
  sps_sync u_st  (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(program_start_input), .dout(start_s));
  sps_sync u_ps  (.ref_clk(ref_clk), .sys_rst(sys_rst), .din(program_select_input), .dout(psel_s));

  // Interval table base index of a program
  function automatic logic [IX_W-1:0] prog_base(input logic two);
    prog_base = two ? IX_W'(P1_IVL) : IX_RST;
  endfunction : prog_base

  // Interval table last index of a program
  function automatic logic [IX_W-1:0] prog_last(input logic two, input logic casc);
    prog_last = (two || casc) ? IX_W'(TOT_IVL - 1) : IX_W'(P1_IVL - 1);
  endfunction : prog_last

  // State registers
  sps_state_e        st_ff, nxt_st;
  logic              int_ff, nxt_int;           // Internal-select flip-flop
  logic              cb_ff, nxt_cb;             // Start flip-flop
  logic              start_d_ff, nxt_start_d;   // Start level delayed
  logic              two_ff, nxt_two;           // Latched program choice
  logic [IX_W-1:0]   idx_ff, nxt_idx;
  logic [TM_W-1:0]   rem_ff, nxt_rem;
  logic [SP_W-1:0]   wp_ff, nxt_wp;             // Program setpoint
  logic [SP_W-1:0]   wi_ff, nxt_wi;             // Internal setpoint
  logic [SP_W-1:0]   seg_start_ff, nxt_seg_start;
  logic [NOUT-1:0]   out_ff, nxt_out;
  logic [SP_W-1:0]   asp_ff, nxt_asp;           // Active setpoint
  logic [31:0]       div_ff, nxt_div;
  logic              tick;
  logic              run, start_rise, end_evt, prg_rst;
  logic [IX_W-1:0]   nidx;
  sps_ivl_s          cur;
  logic signed [SP_W+1:0] diff;
  logic signed [SP_W+TM_W+3:0] prod;           // Ramp product, wide enough for full span
  logic [TM_W-1:0]   dur_cur;

  // Time base divider pulse
  assign tick = (div_ff == 32'(TICK_DIV - 1));

  // Decode current interval and run condition
  always_comb
  begin
    cur        = ivl_tab[idx_ff];
    start_rise = start_s & ~start_d_ff;
    run        = ~int_ff & cb_ff & ~manual_mode & (st_ff == ST_RUN);
    // Last table entry never indexes past the end
    nidx       = (idx_ff == IX_W'(TOT_IVL - 1)) ? idx_ff : idx_ff + 4'h1;
    dur_cur    = (cur.dur == TM_RST) ? 16'h0001 : cur.dur;
    end_evt    = run & tick & (rem_ff <= 16'h0001) &
                 ((idx_ff == prog_last(two_ff, cfg.cascade_en)) || (ivl_tab[nidx].dur == TM_RST));
    prg_rst    = rst_s | (manual_mode & int_ff);
  end

  // Sequencer next-state logic
  always_comb
  begin
    nxt_st        = st_ff;
    nxt_int       = int_ff;
    nxt_cb        = cb_ff;
    nxt_start_d   = start_s;
    nxt_two       = two_ff;
    nxt_idx       = idx_ff;
    nxt_rem       = rem_ff;
    nxt_wp        = wp_ff;
    nxt_wi        = wi_ff;
    nxt_seg_start = seg_start_ff;
    nxt_out       = out_ff;
    nxt_div       = tick ? 32'h0 : div_ff + 32'h1;
    diff          = '0;
    prod          = '0;
    // Front key toggles internal select
    if (int_key_press)
      nxt_int = ~int_ff;
    // Start flip-flop: dynamic latches edges, static follows level
    if (cfg.start_input_static_dynamic_select == START_DYN)
    begin
      if (start_rise)
        nxt_cb = 1'b1;
    end
    else
      nxt_cb = start_s;
    case (st_ff)
      ST_IDLE:
      begin
        if ((start_rise & ~int_ff) | (int_key_press & int_ff & start_s) |
            (~int_ff & cb_ff & ~manual_mode))
        begin
          // choose program at start
          // Pin or menu setting picks program two
          nxt_two       = psel_s | cfg.program_config_menu;
          nxt_idx       = prog_base(nxt_two);
          nxt_rem       = ivl_tab[prog_base(nxt_two)].dur;
          nxt_seg_start = wi_ff;
          nxt_st        = ST_RUN;
          // Key start also arms the start flip-flop
          nxt_cb        = 1'b1;
        end
      end
      ST_RUN:
      begin
        if (end_evt)
        begin
          nxt_st  = ST_IDLE;
          nxt_wp  = cur.target;
          nxt_idx = prog_base(two_ff);
          nxt_rem = TM_RST;
          if (cfg.start_input_static_dynamic_select != START_DYN)
            nxt_int = 1'b1;
          // dynamic clears start, new edge wins
          else
            nxt_cb = start_rise;
          if (cfg.safety_tracking_select)
            nxt_wi = safety_setpoint;
          else if (cfg.setpoint_tracking_select != TRACK_OFF)
            nxt_wi = cur.target;
        end
        else if (run & tick)
        begin
          if (rem_ff <= 16'h0001)
          begin
            nxt_idx       = nidx;
            nxt_rem       = ivl_tab[nidx].dur;
            nxt_seg_start = cur.target;
            nxt_wp        = cur.target;
          end
          else
          begin
            nxt_rem = rem_ff - 16'h0001;
            diff    = $signed({2'b00, cur.target}) - $signed({2'b00, seg_start_ff});
            prod    = 36'(diff) * $signed({20'h00000, rem_ff - 16'h0001});
            nxt_wp  = SP_W'($signed({20'h00000, cur.target}) - prod / $signed({20'h00000, dur_cur}));
          end
        end
        else if (~run)
        begin
          if (cfg.setpoint_tracking_select != TRACK_OFF)
            nxt_wi = wp_ff;
          nxt_seg_start = wi_ff;
          nxt_st        = ST_STOP;
        end
      end
      default:
      begin
        // Stopped: ramp restarts from internal setpoint
        nxt_seg_start = wi_ff;
        nxt_rem       = rem_ff;
        if (~int_ff & cb_ff & ~manual_mode)
          nxt_st = ST_RUN;
      end
    endcase
    if (st_ff != ST_IDLE)
      nxt_out = cur.outs;
    if (prg_rst)
    begin
      nxt_st  = ST_IDLE;
      nxt_idx = prog_base(two_ff);
      nxt_rem = TM_RST;
      nxt_wp  = wi_ff;
    end
    // Active setpoint source, registered for a clean output
    nxt_asp = (nxt_int | ~nxt_cb) ? nxt_wi : nxt_wp;
  end

  // Register update
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff        <= ST_IDLE;
      int_ff       <= 1'b1;
      cb_ff        <= 1'b0;
      start_d_ff   <= 1'b0;
      two_ff       <= 1'b0;
      idx_ff       <= IX_RST;
      rem_ff       <= TM_RST;
      wp_ff        <= SP_RST;
      wi_ff        <= SP_RST;
      seg_start_ff <= SP_RST;
      out_ff       <= OUT_RST;
      asp_ff       <= SP_RST;
      div_ff       <= 32'h0;
    end
    else
    begin
      st_ff        <= nxt_st;
      int_ff       <= nxt_int;
      cb_ff        <= nxt_cb;
      start_d_ff   <= nxt_start_d;
      two_ff       <= nxt_two;
      idx_ff       <= nxt_idx;
      rem_ff       <= nxt_rem;
      wp_ff        <= nxt_wp;
      wi_ff        <= nxt_wi;
      seg_start_ff <= nxt_seg_start;
      out_ff       <= nxt_out;
      asp_ff       <= nxt_asp;
      div_ff       <= nxt_div;
    end
  end

  // Registered status outputs
  logic run_ff, led_ff, alm_ff;
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_ff <= 1'b0;
      led_ff <= 1'b1;
      alm_ff <= 1'b1;
    end
    else
    begin
      run_ff <= run;
      led_ff <= nxt_int;
      alm_ff <= ~run | manual_mode;
    end
  end

  assign active_setpoint                = asp_ff;
  assign internal_setpoint              = wi_ff;
  assign program_outputs                = out_ff;
  assign clock_running                  = run_ff;
  assign internal_led                   = led_ff;
  assign internal_setpoint_ready_output = led_ff;
  assign no_program_operation_alarm     = alm_ff;
  assign interval_index                 = idx_ff;
  assign remaining_time                 = rem_ff;
  assign program_two_active             = two_ff;
endmodule : sps_core
`default_nettype wire

// [bench/sps_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// Front keys and start pin beside the sequencer
module sps_partner
  import sps_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic start_lvl,
  output logic      int_key_press,
  output logic      program_start_input
);
  // Key idles low
  initial int_key_press = 1'b0;

  task automatic press();
    @(negedge ref_clk);
    int_key_press = 1'b1;
    @(negedge ref_clk);
    int_key_press = 1'b0;
  endtask : press

  assign program_start_input = start_lvl;
endmodule : sps_partner
`default_nettype wire

// [bench/sps_core_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// Port checker for the sequencer
module sps_core_monitor
  import sps_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC
)
(
  input wire logic            ref_clk,
  input wire logic            sys_rst,
  input wire logic            program_reset_input,
  input wire logic            manual_mode,
  input wire sps_ivl_s        ivl_tab [TOT_IVL],
  input wire logic [SP_W-1:0] active_setpoint,
  input wire logic [SP_W-1:0] internal_setpoint,
  input wire logic [NOUT-1:0] program_outputs,
  input wire logic            clock_running,
  input wire logic            internal_led,
  input wire logic            internal_setpoint_ready_output,
  input wire logic            no_program_operation_alarm,
  input wire logic [IX_W-1:0] interval_index,
  input wire logic [TM_W-1:0] remaining_time,
  input wire logic            program_two_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  stop_alarm_a: assert property (!clock_running [*2] |-> no_program_operation_alarm)
    else $error("alarm low while stopped");
  run_quiet_a: assert property (clock_running [*2] |-> !no_program_operation_alarm)
    else $error("alarm high while running");
  int_stops_a: assert property (internal_led [*3] |-> !clock_running && internal_setpoint_ready_output)
    else $error("internal setpoint but running");
  int_source_a: assert property (internal_led [*2] |-> active_setpoint == internal_setpoint)
    else $error("active not internal");
  manual_stop_a: assert property (manual_mode [*3] |-> !clock_running)
    else $error("running in manual");
  reset_home_a: assert property (program_reset_input [*6] |-> interval_index == IX_RST)
    else $error("reset did not home");
  tick_down_a: assert property (clock_running && $past(clock_running) && $stable(interval_index)
    |-> remaining_time <= $past(remaining_time))
    else $error("remaining time rose");
  outs_match_a: assert property (clock_running && $past(clock_running) && $stable(interval_index)
    && !program_two_active |-> program_outputs == ivl_tab[interval_index].outs)
    else $error("outputs differ from interval");

  // Main scenarios
  cover property (clock_running ##1 !clock_running);
  cover property (clock_running && $changed(interval_index));
  cover property (clock_running && program_two_active);
endmodule : sps_core_monitor

bind sps_core sps_core_monitor #(.TICK_DIV(TICK_DIV)) u_sps_core_monitor (.*);
`default_nettype wire

// [bench/sps_core_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the sequencer
module sps_core_tb_top
  import sps_pkg::*;
;
  // Rows: manual, internal, start, led, run, ready
  localparam logic [5:0] ROWS [7] = '{6'h1D, 6'h0A, 6'h00, 6'h0A, 6'h28, 6'h3D, 6'h15};
  logic            ref_clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic            rst_in = 1'b0, sel_in = 1'b0, man = 1'b0, start_lvl = 1'b0;
  logic            key, start_pin, run, led, rdy, alm, two;
  logic [SP_W-1:0] act_sp, int_sp;
  logic [SP_W-1:0] safe_sp = 16'h5A5A;
  logic [NOUT-1:0] pouts;
  logic [IX_W-1:0] idx;
  logic [TM_W-1:0] rem;
  sps_cfg_s        cfg = '0;
  sps_ivl_s        tab [TOT_IVL];
  int              failures = 0, checked = 0, cur_int = 1;

  // 4 ns clock
  always #2 ref_clk = ~ref_clk;

  sps_core #(.TICK_DIV(4)) u_sps_core (
    .ref_clk                        (ref_clk),
    .sys_rst                        (sys_rst),
    .program_reset_input            (rst_in),
    .program_start_input            (start_pin),
    .program_select_input           (sel_in),
    .manual_mode                    (man),
    .int_key_press                  (key),
    .cfg                            (cfg),
    .ivl_tab                        (tab),
    .safety_setpoint                (safe_sp),
    .active_setpoint                (act_sp),
    .internal_setpoint              (int_sp),
    .program_outputs                (pouts),
    .clock_running                  (run),
    .internal_led                   (led),
    .internal_setpoint_ready_output (rdy),
    .no_program_operation_alarm     (alm),
    .interval_index                 (idx),
    .remaining_time                 (rem),
    .program_two_active             (two)
  );

  sps_partner u_sps_partner (
    .ref_clk             (ref_clk),
    .start_lvl           (start_lvl),
    .int_key_press       (key),
    .program_start_input (start_pin)
  );

  // Compare one value
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Verdict and end of run
  task automatic report_and_stop();
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // Front key to wanted internal select
  task automatic key_to(input int v);
    if (cur_int != v)
    begin
      u_sps_partner.press();
      cur_int = v;
    end
  endtask : key_to

  // Bounded waits
  task automatic wait_run(input logic v);
    for (int n = 0; n < 400 && run !== v; n++)
      cyc(1);
    // Limit reached counts as a mismatch
    if (run !== v)
      failures++;
  endtask : wait_run

  task automatic wait_idx(input logic [IX_W-1:0] v);
    for (int n = 0; n < 400 && idx !== v; n++)
      cyc(1);
    // Limit reached counts as a mismatch
    if (idx !== v)
      failures++;
  endtask : wait_idx

  // Reset with new selectors
  task automatic restart(input logic [1:0] st, input logic sf, input logic [1:0] tr);
    cfg = '{st, tr, sf, 1'b0, 1'b0};
    sys_rst = 1'b1;
    start_lvl = 1'b0;
    cyc(4);
    sys_rst = 1'b0;
    cur_int = 1;
    cyc(6);
  endtask : restart

  // Long table for the mode rows
  initial foreach (tab[i]) tab[i] = '{16'h0040, 16'h0100, 6'h01};

  // Main sequence
  initial
  begin
    cyc(4);
    sys_rst = 1'b0;
    cyc(6);
    foreach (ROWS[i])
    begin
      man = ROWS[i][5];
      start_lvl = ROWS[i][3];
      key_to(ROWS[i][4]);
      cyc(8);
      cmp({led, run, rdy, alm}, {ROWS[i][2:0], ~ROWS[i][1]});
    end
    cmp(idx, IX_RST);
    man = 1'b0;
    // Short static program, safety tracking
    foreach (tab[i]) tab[i] = '0;
    tab[0] = '{16'h0003, 16'h0100, 6'h15};
    tab[1] = '{16'h0002, 16'h0200, 6'h2A};
    tab[10] = '{16'h0002, 16'h0300, 6'h3F};
    restart(2'h0, 1'b1, 2'h0);
    start_lvl = 1'b1;
    key_to(0);
    wait_run(1'b1);
    cmp(pouts, tab[0].outs);
    wait_idx(1);
    cyc(1);
    cmp(rem, tab[1].dur);
    cmp(pouts, tab[1].outs);
    wait_run(1'b0);
    cyc(3);
    cmp({led, idx}, {1'b1, IX_RST});
    cmp(int_sp, safe_sp);
    cmp(act_sp, safe_sp);
    // Dynamic start, forced start pin
    restart(START_DYN, 1'b0, 2'h0);
    start_lvl = 1'b1;
    key_to(0);
    wait_run(1'b1);
    wait_run(1'b0);
    cyc(8);
    cmp({led, run}, 2'h0);
    cmp(int_sp, tab[1].target);
    key_to(1);
    key_to(0);
    wait_run(1'b1);
    cmp(run, 1'b1);
    wait_run(1'b0);
    start_lvl = 1'b0;
    cyc(6);
    start_lvl = 1'b1;
    wait_run(1'b1);
    cmp(run, 1'b1);
    // Reset input mid-run
    wait_idx(1);
    rst_in = 1'b1;
    cyc(8);
    cmp(idx, IX_RST);
    rst_in = 1'b0;
    cyc(10);
    cmp({run, idx}, {1'b1, IX_RST});
    // Program two, tracking off
    sel_in = 1'b1;
    restart(2'h0, 1'b0, TRACK_OFF);
    start_lvl = 1'b1;
    key_to(0);
    wait_run(1'b1);
    cmp(two, 1'b1);
    key_to(1);
    cyc(8);
    cmp(int_sp, SP_RST);
    report_and_stop();
  end

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    report_and_stop();
  end
endmodule : sps_core_tb_top
`default_nettype wire
